// >>> hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;
  // Per bit: only take a change once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_out[i];
    end
  endgenerate
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_out <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_out <= level_nxt;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> hw/univ_shreg.sv
// Four-stage bidirectional universal shift register
`timescale 1ns/1ps
`default_nettype none
module univ_shreg (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Device pins
  input wire logic clear_b_in,
  input wire logic dev_clk_in,
  input wire logic mode_sel_hi_in,
  input wire logic mode_sel_lo_in,
  input wire logic ser_right_in,
  input wire logic ser_left_in,
  input wire logic [shreg_pkg::STAGES-1:0] par_in,
  // Stage outputs
  output logic output1_out,
  output logic output2_out,
  output logic output3_out,
  output logic output4_out
);
  import shreg_pkg::*;
  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  // Pins are async to ref_clk_in, so all pass the filter together
  logic [9:0] pins_raw;
  logic [9:0] pins_lvl;
  logic dclk_prev_r;
  shreg_if bus ();
  assign pins_raw = {clear_b_in, dev_clk_in, mode_sel_hi_in, mode_sel_lo_in,
                     ser_right_in, ser_left_in, par_in};
  pin_sync #(.W(10)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(pins_raw),
    .level_out(pins_lvl)
  );
  assign bus.clear_b = pins_lvl[9];
  assign bus.edge_rise = pins_lvl[8] & ~dclk_prev_r;
  assign bus.mode = pins_lvl[7:6];
  assign bus.ser_right = pins_lvl[5];
  assign bus.ser_left = pins_lvl[4];
  assign bus.par = pins_lvl[3:0];
  // ---------------------------------------------------------------
  // Device clock edge
  // ---------------------------------------------------------------
  // Filter leaves reset low, so a pin already high would fake a rise;
  // while clear is low the previous level reads high instead.
  // Limitation: the clock pin must rise at least one clock after clear release.
  logic dclk_prev_nxt;
  assign dclk_prev_nxt = bus.clear_b ? pins_lvl[8] : 1'h1;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      dclk_prev_r <= 1'h1;
    end else begin
      dclk_prev_r <= dclk_prev_nxt;
    end
  end
  // ---------------------------------------------------------------
  // Stage array, stage 0 is output1
  // ---------------------------------------------------------------
  logic [STAGES-1:0] stage_r;
  logic [STAGES-1:0] stage_nxt;
  logic [STAGES-1:0] shr_val;
  logic [STAGES-1:0] shl_val;
  logic [STAGES-1:0] mode_val;
  mode_t mode_cur;
  assign mode_cur = mode_t'(bus.mode);
  assign shr_val = {stage_r[STAGES-2:0], bus.ser_right};
  assign shl_val = {bus.ser_left, stage_r[STAGES-1:1]};
  // ---------------------------------------------------------------
  // Edge decode, one strobe per mode except hold
  // ---------------------------------------------------------------
  // Hold needs no edge; it is the level of both selects, gated by clear high
  logic upd_edge;
  logic load_edge;
  logic shr_edge;
  logic shl_edge;
  logic hold_sel;
  logic cause_any;
  assign upd_edge = bus.clear_b & bus.edge_rise;
  assign load_edge = upd_edge & (mode_cur == MODE_LOAD);
  assign shr_edge = upd_edge & (mode_cur == MODE_SHR);
  assign shl_edge = upd_edge & (mode_cur == MODE_SHL);
  assign hold_sel = bus.clear_b & (mode_cur == MODE_HOLD);
  assign cause_any = upd_edge | ~bus.clear_b;
  always_comb begin
    case (mode_cur)
      MODE_LOAD: mode_val = bus.par;
      MODE_SHR: mode_val = shr_val;
      MODE_SHL: mode_val = shl_val;
      MODE_HOLD: mode_val = stage_r;
      default: mode_val = stage_r;
    endcase
  end
  // Clear first, then only a rising edge may update; else hold
  assign stage_nxt = !bus.clear_b ? STAGE_RST :
                     bus.edge_rise ? mode_val : stage_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      stage_r <= STAGE_RST;
    end else begin
      stage_r <= stage_nxt;
    end
  end
  // Outputs are direct flops, no enable
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      {output4_out, output3_out, output2_out, output1_out} <= STAGE_RST;
    end else begin
      {output4_out, output3_out, output2_out, output1_out} <= stage_nxt;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [STAGES-1:0] outs;
  assign outs = {output4_out, output3_out, output2_out, output1_out};
  // ---------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------
  // Keeps the bit taken on the last update, so that two shift-right
  // edges in a row can be followed through two stages
  logic stage_upd;
  logic last_sr_r;
  logic last_sr_nxt;
  logic shr_prev_r;
  logic shr_prev_nxt;
  assign stage_upd = !bus.clear_b || bus.edge_rise;
  assign last_sr_nxt = stage_upd ? bus.ser_right : last_sr_r;
  assign shr_prev_nxt = stage_upd ? shr_edge : shr_prev_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      last_sr_r <= 1'h0;
      shr_prev_r <= 1'h0;
    end else begin
      last_sr_r <= last_sr_nxt;
      shr_prev_r <= shr_prev_nxt;
    end
  end
  property p_clear_low;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !bus.clear_b |=> (outs == 4'h0);
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("clear did not zero");
  property p_no_edge_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && !bus.edge_rise) |=> $stable(outs);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("changed without edge");
  property p_only_edge;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && dclk_prev_r) |=> (outs == $past(outs));
  endproperty
  a_only_edge: assert property (p_only_edge) else $error("update off rising edge");
  property p_load;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && bus.edge_rise && bus.mode == 2'h3) |=> (outs == $past(bus.par));
  endproperty
  a_load: assert property (p_load) else $error("parallel load wrong");
  property p_shr;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && bus.edge_rise && bus.mode == 2'h1) |=>
      (outs == {$past(outs[2:0]), $past(bus.ser_right)});
  endproperty
  a_shr: assert property (p_shr) else $error("shift right wrong");
  property p_shl;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && bus.edge_rise && bus.mode == 2'h2) |=>
      (outs == {$past(bus.ser_left), $past(outs[3:1])});
  endproperty
  a_shl: assert property (p_shl) else $error("shift left wrong");
  property p_mode_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (bus.clear_b && bus.mode == 2'h0) |=> $stable(outs);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("hold mode changed");
  property p_mirror;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      ##1 (outs == stage_r);
  endproperty
  a_mirror: assert property (p_mirror) else $error("outputs differ from stages");
  property p_width;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (shr_edge && shr_prev_r) |=> (outs[1] == $past(last_sr_r));
  endproperty
  a_width: assert property (p_width) else $error("serial bit not carried");
  // Reset and clear must win in the very next cycle, not eventually
  property p_rst_zero;
    @(posedge ref_clk_in)
      !rst_b_in |=> (outs == 4'h0);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset did not zero outputs");
  property p_clear_blocks_edge;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !bus.clear_b |=> !bus.edge_rise;
  endproperty
  a_clear_blocks_edge: assert property (p_clear_blocks_edge) else $error("edge during clear");
  property p_one_update;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      bus.edge_rise |=> !bus.edge_rise;
  endproperty
  a_one_update: assert property (p_one_update) else $error("edge strobe too long");
  property p_change_cause;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !$stable(outs) |-> $past(cause_any);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("outputs changed unprompted");
  property p_hold_edge;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (hold_sel && bus.edge_rise) |=> $stable(outs);
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("hold mode took an edge");
endmodule // univ_shreg
`default_nettype wire

// >>> include/shreg_if.sv
// Interface carrying synchronised controls to the stage array
`timescale 1ns/1ps
`default_nettype none
interface shreg_if;
  logic clear_b;
  logic edge_rise;
  logic [1:0] mode;
  logic ser_right;
  logic ser_left;
  logic [3:0] par;
  modport src (output clear_b, edge_rise, mode, ser_right, ser_left, par);
  modport dst (input clear_b, edge_rise, mode, ser_right, ser_left, par);
endinterface
`default_nettype wire

// >>> include/shreg_pkg.sv
// Package of constants and types for the universal shift register
package shreg_pkg;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int STAGES = 4;
  localparam logic [3:0] STAGE_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;
  // ---------------------------------------------------------------
  // Mode encodings, mode_sel_hi in bit 1
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOLD = 2'h0,
    MODE_SHR = 2'h1,
    MODE_LOAD = 2'h3,
    MODE_SHL = 2'h2
  } mode_t;
endpackage

// >>> sim/board_model.sv
// Board-side model that drives the shift register pins
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // Clock
  input wire logic ref_clk_in,
  // Pins
  output logic clear_b_out,
  output logic dev_clk_out,
  output logic mode_sel_hi_out,
  output logic mode_sel_lo_out,
  output logic ser_right_out,
  output logic ser_left_out,
  output logic [3:0] par_out
);
  // ------------------------------------------------------------
  // Pin sequencing
  // ------------------------------------------------------------
  initial begin
    clear_b_out = 1'h1;
    dev_clk_out = 1'h0;
    set_pins(2'h0, 1'h0, 1'h0, 4'h0);
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic set_pins(input logic [1:0] m, input logic sr, input logic sl,
                          input logic [3:0] p);
    {mode_sel_hi_out, mode_sel_lo_out} = m;
    ser_right_out = sr;
    ser_left_out = sl;
    par_out = p;
  endtask
  task automatic set_clear(input logic b);
    clear_b_out = b;
  endtask
  task automatic set_clk(input logic b);
    dev_clk_out = b;
  endtask
  // Levels held 4 cycles each side, so the pin filter never drops an edge
  task automatic pulse();
    cyc(4);
    dev_clk_out = 1'h1;
    cyc(4);
    dev_clk_out = 1'h0;
    cyc(4);
  endtask
endmodule // board_model
`default_nettype wire

// >>> sim/univ_shreg_bench.sv
// Self-checking bench for the universal shift register
`timescale 1ns/1ps
`default_nettype none
module univ_shreg_bench;
  import shreg_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic clr_b, dclk, mhi, mlo, sr, sl;
  logic [3:0] par;
  logic [3:0] q;
  int mismatches = 0;
  int n_compared = 0;
  // Rows: mode, right serial, left serial, parallel, expected outputs
  logic [11:0] rows [7] = '{{MODE_LOAD, 1'h0, 1'h0, 4'hA, 4'hA},
    {MODE_SHR, 1'h1, 1'h0, 4'hF, 4'h5}, {MODE_SHR, 1'h0, 1'h1, 4'hF, 4'hA},
    {MODE_SHL, 1'h0, 1'h1, 4'h0, 4'hD}, {MODE_SHL, 1'h1, 1'h0, 4'hF, 4'h6},
    {MODE_HOLD, 1'h1, 1'h1, 4'hF, 4'h6}, {MODE_LOAD, 1'h1, 1'h1, 4'h9, 4'h9}};
  always #2 ref_clk = ~ref_clk;
  board_model i_board_model (.ref_clk_in(ref_clk), .clear_b_out(clr_b), .dev_clk_out(dclk),
    .mode_sel_hi_out(mhi), .mode_sel_lo_out(mlo), .ser_right_out(sr), .ser_left_out(sl),
    .par_out(par));
  univ_shreg i_univ_shreg (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .clear_b_in(clr_b),
    .dev_clk_in(dclk), .mode_sel_hi_in(mhi), .mode_sel_lo_in(mlo), .ser_right_in(sr),
    .ser_left_in(sl), .par_in(par), .output1_out(q[0]), .output2_out(q[1]),
    .output3_out(q[2]), .output4_out(q[3]));
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [3:0] exp);
    n_compared++;
    if (q !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, q);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    i_board_model.cyc(2);
    rst_b = 1'h1;
    i_board_model.cyc(8);
    chk("after reset", 4'h0);
    foreach (rows[i]) begin
      i_board_model.set_pins(rows[i][11:10], rows[i][9], rows[i][8], rows[i][7:4]);
      i_board_model.pulse();
      chk("table row", rows[i][3:0]);
    end
    // Clear low beats a load edge
    i_board_model.set_clear(1'h0);
    i_board_model.set_pins(MODE_LOAD, 1'h1, 1'h1, 4'hF);
    i_board_model.pulse();
    chk("clear", 4'h0);
    i_board_model.set_clear(1'h1);
    i_board_model.set_pins(MODE_LOAD, 1'h0, 1'h0, 4'h3);
    i_board_model.pulse();
    chk("load after clear", 4'h3);
    // High level and falling edge must not load
    i_board_model.set_pins(MODE_HOLD, 1'h0, 1'h0, 4'h0);
    i_board_model.cyc(4);
    i_board_model.set_clk(1'h1);
    i_board_model.cyc(4);
    i_board_model.set_pins(MODE_LOAD, 1'h1, 1'h1, 4'hC);
    i_board_model.cyc(8);
    chk("clock high", 4'h3);
    i_board_model.set_clk(1'h0);
    i_board_model.cyc(8);
    chk("falling edge", 4'h3);
    i_board_model.set_pins(MODE_SHR, 1'h1, 1'h0, 4'h5);
    i_board_model.cyc(8);
    chk("clock low", 4'h3);
    // Reset in mid-run drops loaded data; pins settle before the next use
    i_board_model.set_pins(MODE_LOAD, 1'h0, 1'h0, 4'h6);
    i_board_model.pulse();
    chk("load before reset", 4'h6);
    rst_b = 1'h0;
    i_board_model.cyc(2);
    chk("during reset", 4'h0);
    rst_b = 1'h1;
    i_board_model.cyc(8);
    chk("after second reset", 4'h0);
    i_board_model.set_pins(MODE_LOAD, 1'h0, 1'h0, 4'h5);
    i_board_model.pulse();
    chk("load after second reset", 4'h5);
    report_and_stop();
  end
  // Whole run is about 184 cycles (about 740 ns); the limit leaves wide margin
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule // univ_shreg_bench
`default_nettype wire
